// File: verilog/mcu8_exec_pkg.sv
// Constants, encodings and carrier types of the 8-bit core execution unit
package mcu8_exec_pkg;
    // Last core clock count of a machine cycle (four clocks per cycle)
    localparam logic [1:0] MCYC_LAST = 2'h3;
    // Data space locations of the core registers, then reset values
    localparam logic [7:0] A_ADDR = 8'hff;
    localparam logic [7:0] X_ADDR = 8'h80;
    localparam logic [7:0] Y_ADDR = 8'h81;
    localparam logic [7:0] SD_BASE = 8'h80;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [11:0] RST_PC = 12'h000;
    // Opcode groups, low nibble of the opcode
    localparam logic [3:0] GRP_JNZ = 4'h0;
    localparam logic [3:0] GRP_CALL = 4'h1;
    localparam logic [3:0] GRP_JNC = 4'h2;
    localparam logic [3:0] GRP_BTST = 4'h3;
    localparam logic [3:0] GRP_JZ = 4'h4;
    localparam logic [3:0] GRP_SDIR = 4'h5;
    localparam logic [3:0] GRP_JC = 4'h6;
    localparam logic [3:0] GRP_IND = 4'h7;
    localparam logic [3:0] GRP_JP = 4'h9;
    localparam logic [3:0] GRP_BSET = 4'hb;
    localparam logic [3:0] GRP_INH = 4'hd;
    localparam logic [3:0] GRP_DIR = 4'hf;
    // Arithmetic functions, opcode bits 7:5
    localparam logic [2:0] FN_ADD = 3'h0;
    localparam logic [2:0] FN_AND = 3'h1;
    localparam logic [2:0] FN_CP = 3'h2;
    localparam logic [2:0] FN_SUB = 3'h3;
    localparam logic [2:0] FN_INC = 3'h4;
    localparam logic [2:0] FN_DEC = 3'h5;
    localparam logic [2:0] FN_CLR = 3'h6;
    // Inherent operations, opcode bits 7:4
    localparam logic [3:0] INH_RET = 4'h1;
    localparam logic [3:0] INH_RETURN_FROM_INTERRUPT = 4'h2;
    localparam logic [3:0] INH_STOP = 4'h3;
    localparam logic [3:0] INH_WAIT = 4'h4;
    localparam logic [3:0] INH_COM = 4'h5;
    localparam logic [3:0] INH_RLC = 4'h6;
    localparam logic [3:0] INH_SLA = 4'h7;
    // Byte counts and machine cycle counts
    localparam logic [2:0] LEN_1 = 3'h1;
    localparam logic [2:0] LEN_2 = 3'h2;
    localparam logic [2:0] LEN_3 = 3'h3;
    localparam logic [2:0] CYC_SHORT = 3'h2;
    localparam logic [2:0] CYC_ALU = 3'h4;
    localparam logic [2:0] CYC_BTST = 3'h5;
    // Branch bases, added to the instruction's own address; then the top return stack slot
    localparam logic [11:0] REL_BASE = 12'h001;
    localparam logic [11:0] BT_BASE = 12'h002;
    localparam logic [2:0] STK_TOP = 3'h5;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } ds_req_t;
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_WAIT = 3'b010,
        ST_STOP = 3'b100
    } core_state_t;
endpackage

// File: verilog/mcu8_core_instruction_exec.sv
// Execution unit: arithmetic, branch, bit, control and jump instructions
// Contract
// - Add/and/compare/subtract: accumulator with memory or immediate
// - Clear/increment/decrement reach all 256 data locations
// - Complement, rotate, shift work on accumulator only
// - Short jumps test one flag, 1 byte, 2 cycles
// - Short jump span is -15 to +16
// - Bit-test jump span is -126 to +129
// - Jump if bit clear: 3 bytes, 5 cycles
// - Jump if bit set: 3 bytes, 5 cycles
// - Bit tests copy tested bit into carry
// - Set/clear reach any bit of any location
// - Set/clear: 2 bytes, 4 cycles, flags kept
// - Jump and call take 12-bit target, call saves
// - Stop becomes wait when watchdog is selected
// - Immediate byte comes from program memory
`timescale 1ns/10ps
module mcu8_core_instruction_exec (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    input wire logic [7:0] I_PM_DATA,
    input wire logic [7:0] I_DS_RDATA,
    input wire logic I_WDG_SEL,
    input wire logic I_WAKE,
    input wire logic I_FLAG_SAVE,
    output logic [11:0] O_PM_ADDR,
    output mcu8_exec_pkg::ds_req_t O_DS_REQ,
    output logic [7:0] O_ACC,
    output logic O_ZERO,
    output logic O_CARRY,
    output logic O_WAIT,
    output logic O_STOP
);
    logic [1:0] div_reg;
    logic [2:0] mc_reg, sp_reg;
    logic [11:0] pc_reg, ipc_reg;
    logic [7:0] ir0_reg, ir1_reg, ir2_reg, ea_reg, opnd_reg;
    logic [7:0] a_reg, x_reg, y_reg, v_reg, w_reg;
    logic z_reg, c_reg, zs_reg, cs_reg;
    logic [11:0] stk [0:5];
    mcu8_exec_pkg::core_state_t state_reg;
    mcu8_exec_pkg::ds_req_t ds_reg;

    // Machine cycle enable
    wire cyc_en = (div_reg == mcu8_exec_pkg::MCYC_LAST);
    wire run = (state_reg == mcu8_exec_pkg::ST_RUN);
    wire [7:0] opc = (mc_reg == 3'h0) ? I_PM_DATA : ir0_reg;
    wire [3:0] grp = opc[3:0];
    wire [2:0] fn = opc[7:5];
    wire [3:0] inh = opc[7:4];
    // Every even code is a relative jump; bit 3 is displacement, not group
    wire is_rel = ~grp[0];
    wire is_bt = (grp == mcu8_exec_pkg::GRP_BTST);
    wire is_bs = (grp == mcu8_exec_pkg::GRP_BSET);
    wire is_call = (grp == mcu8_exec_pkg::GRP_CALL);
    wire is_jp = (grp == mcu8_exec_pkg::GRP_JP);
    wire is_sd = (grp == mcu8_exec_pkg::GRP_SDIR) & ~opc[7];
    wire is_ind = (grp == mcu8_exec_pkg::GRP_IND)
        & (fn <= mcu8_exec_pkg::FN_DEC);
    wire is_dir = (grp == mcu8_exec_pkg::GRP_DIR)
        & (fn <= mcu8_exec_pkg::FN_CLR);
    wire is_inh = (grp == mcu8_exec_pkg::GRP_INH);
    wire is_ctl = is_inh & (inh <= mcu8_exec_pkg::INH_WAIT);
    wire is_acc1 = is_inh & (inh >= mcu8_exec_pkg::INH_COM)
        & (inh <= mcu8_exec_pkg::INH_SLA);
    wire is_alu = is_ind | is_dir | is_sd;
    wire use_imm = is_dir & opc[4] & (fn <= mcu8_exec_pkg::FN_SUB);
    wire [2:0] afn = is_sd ? (opc[4] ? mcu8_exec_pkg::FN_DEC
        : mcu8_exec_pkg::FN_INC) : fn;
    wire is_clr = is_dir & (fn == mcu8_exec_pkg::FN_CLR);
    // Byte and cycle counts per class
    wire [2:0] len = is_bt ? mcu8_exec_pkg::LEN_3
        : (is_bs | is_call | is_jp) ? mcu8_exec_pkg::LEN_2
        : is_clr ? mcu8_exec_pkg::LEN_3
        : is_dir ? mcu8_exec_pkg::LEN_2
        : (is_inh & inh == mcu8_exec_pkg::INH_SLA) ? mcu8_exec_pkg::LEN_2
        : mcu8_exec_pkg::LEN_1;
    wire [2:0] ncyc = is_bt ? mcu8_exec_pkg::CYC_BTST
        : (is_alu | is_acc1 | is_bs | is_call | is_jp)
        ? mcu8_exec_pkg::CYC_ALU : mcu8_exec_pkg::CYC_SHORT;
    wire step = cyc_en & run;
    wire start = step & (mc_reg == 3'h0);
    wire fetch = step & (mc_reg < len);
    wire samp = step & (mc_reg == 3'(ncyc - 3'h2));
    wire last = step & (mc_reg == 3'(ncyc - 3'h1));
    // Reads of core registers never reach the external data space
    wire hit_a = (ea_reg == mcu8_exec_pkg::A_ADDR);
    wire hit_x = (ea_reg == mcu8_exec_pkg::X_ADDR);
    wire hit_y = (ea_reg == mcu8_exec_pkg::Y_ADDR);
    wire hit_v = (ea_reg == 8'(mcu8_exec_pkg::SD_BASE + 8'h02));
    wire hit_w = (ea_reg == 8'(mcu8_exec_pkg::SD_BASE + 8'h03));
    wire hit_int = hit_a | hit_x | hit_y | hit_v | hit_w;
    wire [7:0] ds_val = hit_a ? a_reg : hit_x ? x_reg : hit_y ? y_reg
        : hit_v ? v_reg : hit_w ? w_reg : I_DS_RDATA;
    wire [7:0] ea_first = is_ind ? (opc[4] ? y_reg : x_reg)
        : is_sd ? (mcu8_exec_pkg::SD_BASE | {6'h00, opc[6:5]})
        : mcu8_exec_pkg::A_ADDR;
    wire [7:0] b_op = use_imm ? ir1_reg : opnd_reg;
    wire [8:0] sum9 = {1'b0, a_reg} + {1'b0, b_op};
    wire [8:0] dif9 = {1'b0, a_reg} - {1'b0, b_op};
    wire [7:0] bmask = 8'h01 << opc[7:5];
    wire tbit = opnd_reg[opc[7:5]];
    wire bt_take = opc[4] ? tbit : ~tbit;
    wire rel_take = grp[2] ? (grp[1] ? c_reg : z_reg)
        : (grp[1] ? ~c_reg : ~z_reg);
    wire [11:0] rel_tgt = ipc_reg + mcu8_exec_pkg::REL_BASE
        + {{7{opc[7]}}, opc[7:3]};
    wire [11:0] bt_tgt = ipc_reg + mcu8_exec_pkg::BT_BASE
        + {{4{ir2_reg[7]}}, ir2_reg};
    wire [11:0] far_tgt = {opc[7:4], ir1_reg};
    wire [2:0] sp_dec = 3'(sp_reg - 3'h1);
    wire do_ret = is_ctl & (inh == mcu8_exec_pkg::INH_RET
        | inh == mcu8_exec_pkg::INH_RETURN_FROM_INTERRUPT);

    logic [7:0] res;
    logic c_new, z_aff, c_aff, wr_acc, wr_mem;
    always_comb begin
        res = 8'h00;
        c_new = c_reg;
        z_aff = 1'b0;
        c_aff = 1'b0;
        wr_acc = 1'b0;
        wr_mem = 1'b0;
        if (is_alu) begin
            z_aff = ~is_clr;
            c_aff = (afn <= mcu8_exec_pkg::FN_SUB);
            unique case (afn)
                mcu8_exec_pkg::FN_ADD: begin
                    res = sum9[7:0];
                    c_new = sum9[8];
                    wr_acc = 1'b1;
                end
                mcu8_exec_pkg::FN_AND: begin
                    res = a_reg & b_op;
                    c_new = 1'b0;
                    wr_acc = 1'b1;
                end
                mcu8_exec_pkg::FN_CP: begin
                    res = dif9[7:0];
                    c_new = dif9[8];
                end
                mcu8_exec_pkg::FN_SUB: begin
                    res = dif9[7:0];
                    c_new = dif9[8];
                    wr_acc = 1'b1;
                end
                mcu8_exec_pkg::FN_INC: begin
                    res = 8'(opnd_reg + 8'h01);
                    wr_mem = 1'b1;
                end
                mcu8_exec_pkg::FN_DEC: begin
                    res = 8'(opnd_reg - 8'h01);
                    wr_mem = 1'b1;
                end
                default: begin
                    res = 8'h00;
                    wr_mem = 1'b1;
                end
            endcase
        end else if (is_acc1) begin
            z_aff = 1'b1;
            c_aff = 1'b1;
            c_new = a_reg[7];
            wr_acc = 1'b1;
            if (inh == mcu8_exec_pkg::INH_COM) begin
                res = ~a_reg;
            end else if (inh == mcu8_exec_pkg::INH_RLC) begin
                res = {a_reg[6:0], c_reg};
            end else begin
                res = {a_reg[6:0], 1'b0};
            end
        end else if (is_bs) begin
            res = opc[4] ? (opnd_reg | bmask) : (opnd_reg & ~bmask);
            wr_mem = 1'b1;
        end
    end

    wire ex_wr = last & wr_mem;
    wire ext_wr = ex_wr & ~hit_int;
    wire a_wr = last & (wr_acc | (wr_mem & hit_a));

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= 2'(div_reg + 2'h1);
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            mc_reg <= 3'h0;
            ipc_reg <= mcu8_exec_pkg::RST_PC;
            ir0_reg <= mcu8_exec_pkg::RST_BYTE;
            ir1_reg <= mcu8_exec_pkg::RST_BYTE;
            ir2_reg <= mcu8_exec_pkg::RST_BYTE;
            ea_reg <= mcu8_exec_pkg::RST_BYTE;
            opnd_reg <= mcu8_exec_pkg::RST_BYTE;
        end else begin
            if (step) begin
                mc_reg <= last ? 3'h0 : 3'(mc_reg + 3'h1);
            end
            if (start) begin
                ipc_reg <= pc_reg;
                ir0_reg <= I_PM_DATA;
                ea_reg <= ea_first;
            end
            if (fetch & mc_reg == 3'h1) begin
                ir1_reg <= I_PM_DATA;
                if (is_dir | is_bt | is_bs) begin
                    ea_reg <= I_PM_DATA;
                end
            end
            if (fetch & mc_reg == 3'h2) begin
                ir2_reg <= I_PM_DATA;
            end
            if (samp) begin
                opnd_reg <= ds_val;
            end
        end
    end

    // Program counter and return stack; overflow overwrites the top slot
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            pc_reg <= mcu8_exec_pkg::RST_PC;
            sp_reg <= 3'h0;
        end else if (last & is_rel & rel_take) begin
            pc_reg <= rel_tgt;
        end else if (last & is_bt & bt_take) begin
            pc_reg <= bt_tgt;
        end else if (last & (is_jp | is_call)) begin
            pc_reg <= far_tgt;
            if (is_call) begin
                stk[sp_reg] <= pc_reg;
                if (sp_reg != mcu8_exec_pkg::STK_TOP) begin
                    sp_reg <= 3'(sp_reg + 3'h1);
                end
            end
        end else if (last & do_ret & sp_reg != 3'h0) begin
            pc_reg <= stk[sp_dec];
            sp_reg <= sp_dec;
        end else if (fetch) begin
            pc_reg <= 12'(pc_reg + 12'h001);
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            a_reg <= 8'h00;
            x_reg <= 8'h00;
            y_reg <= 8'h00;
            v_reg <= 8'h00;
            w_reg <= 8'h00;
        end else begin
            if (a_wr) begin
                a_reg <= res;
            end
            if (ex_wr & hit_x) begin
                x_reg <= res;
            end
            if (ex_wr & hit_y) begin
                y_reg <= res;
            end
            if (ex_wr & hit_v) begin
                v_reg <= res;
            end
            if (ex_wr & hit_w) begin
                w_reg <= res;
            end
        end
    end

    // Flags change only where the class allows it
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            z_reg <= 1'b0;
            c_reg <= 1'b0;
            zs_reg <= 1'b0;
            cs_reg <= 1'b0;
        end else begin
            if (I_FLAG_SAVE) begin
                zs_reg <= z_reg;
                cs_reg <= c_reg;
            end
            if (last & z_aff) begin
                z_reg <= (res == 8'h00);
            end
            if (last & c_aff) begin
                c_reg <= c_new;
            end else if (last & is_bt) begin
                c_reg <= tbit;
            end else if (last & is_ctl & inh == mcu8_exec_pkg::INH_RETURN_FROM_INTERRUPT) begin
                z_reg <= zs_reg;
                c_reg <= cs_reg;
            end
        end
    end

    // Data space write is a one-clock strobe after the last machine cycle
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            ds_reg <= '0;
            state_reg <= mcu8_exec_pkg::ST_RUN;
        end else begin
            ds_reg.addr <= ea_reg;
            ds_reg.we <= ext_wr;
            ds_reg.re <= samp & ~hit_int;
            if (ext_wr) begin
                ds_reg.wdata <= res;
            end
            if (last & is_ctl & inh == mcu8_exec_pkg::INH_STOP) begin
                state_reg <= I_WDG_SEL ? mcu8_exec_pkg::ST_WAIT
                    : mcu8_exec_pkg::ST_STOP;
            end else if (last & is_ctl & inh == mcu8_exec_pkg::INH_WAIT) begin
                state_reg <= mcu8_exec_pkg::ST_WAIT;
            end else if (!run & I_WAKE) begin
                state_reg <= mcu8_exec_pkg::ST_RUN;
            end
        end
    end

    assign O_PM_ADDR = pc_reg;
    assign O_DS_REQ = ds_reg;
    assign O_ACC = a_reg;
    assign O_ZERO = z_reg;
    assign O_CARRY = c_reg;
    assign O_WAIT = (state_reg == mcu8_exec_pkg::ST_WAIT);
    assign O_STOP = (state_reg == mcu8_exec_pkg::ST_STOP);

    a_rel_timing: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_N) start & is_rel |-> ##8 start)
        else $error("short jump did not end in two machine cycles");
    a_rel_span: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_N) last & is_rel & rel_take |=>
        ($signed(pc_reg - ipc_reg) >= -15)
        && ($signed(pc_reg - ipc_reg) <= 16))
        else $error("short jump target out of span");
    a_bt_span: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_N) last & is_bt & bt_take |=>
        ($signed(pc_reg - ipc_reg) >= -126)
        && ($signed(pc_reg - ipc_reg) <= 129))
        else $error("bit test target out of span");
    a_bt_clear: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_N) start & is_bt |-> ##20 start)
        else $error("bit test did not end in five machine cycles");
    a_bt_carry: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_N) last & is_bt |=>
        c_reg == $past(tbit) && z_reg == $past(z_reg))
        else $error("tested bit not copied to carry");
    a_bit_op: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_N) start & is_bs |-> ##13 ($stable(c_reg)
        && $stable(z_reg)) ##3 start)
        else $error("bit set or clear timing or flags wrong");
    a_stop_wait: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_N) last & is_ctl
        & inh == mcu8_exec_pkg::INH_STOP & I_WDG_SEL |=> O_WAIT && !O_STOP)
        else $error("stop entered while watchdog selected");
    a_inc_carry: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_N) last & is_alu & (afn == mcu8_exec_pkg::FN_INC
        | afn == mcu8_exec_pkg::FN_DEC) |=> $stable(c_reg))
        else $error("increment or decrement changed carry");
    a_zero_flag: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RST_N) last & z_aff |=> z_reg == ($past(res) == 0))
        else $error("zero flag does not match result");
endmodule

// File: bench/mcu8_mem_model.sv
// Program memory and data space models seen by the execution unit
`timescale 1ns/10ps
module mcu8_mem_model (
    input wire logic i_clk,
    input wire logic [11:0] i_pm_addr,
    input wire mcu8_exec_pkg::ds_req_t i_req,
    output logic [7:0] o_pm_data,
    output logic [7:0] o_ds_rdata
);
    logic [7:0] pm [0:4095];
    // Plain RAM, no port or read-only cells, so bit ops are harmless
    logic [7:0] ds [0:255];
    wire core_cell = (i_req.addr == 8'hff) || (i_req.addr[7:2] == 6'h20);
    assign o_pm_data = pm[i_pm_addr];
    // Core-owned cells are not ours to answer, so show junk there
    assign o_ds_rdata = core_cell ? ~ds[i_req.addr] : ds[i_req.addr];
    always @(posedge i_clk) begin
        if (i_req.we && !core_cell) begin
            ds[i_req.addr] <= i_req.wdata;
        end
    end
endmodule

// File: bench/tb.sv
// Self-checking bench comparing the execution unit with an opcode model
`timescale 1ns/10ps
module tb;
    logic sys_clk, rst_n, wdg_sel, wake, flag_save;
    logic [7:0] pm_data, ds_rdata, acc;
    logic [11:0] pm_addr;
    mcu8_exec_pkg::ds_req_t ds_req;
    logic zf, cf, wt, st;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h37;
    logic [11:0] m_pc;
    logic [7:0] m_a;
    logic [7:0] m_r [0:3];
    logic [7:0] m_ds [0:255];
    logic m_z, m_c, m_sz, m_sc, m_wt, m_st;
    int stk [$];

    mcu8_core_instruction_exec uut (.I_SYS_CLK(sys_clk), .I_RST_N(rst_n),
        .I_PM_DATA(pm_data), .I_DS_RDATA(ds_rdata), .I_WDG_SEL(wdg_sel),
        .I_WAKE(wake), .I_FLAG_SAVE(flag_save), .O_PM_ADDR(pm_addr),
        .O_DS_REQ(ds_req), .O_ACC(acc), .O_ZERO(zf), .O_CARRY(cf),
        .O_WAIT(wt), .O_STOP(st));
    mcu8_mem_model mem (.i_clk(sys_clk), .i_pm_addr(pm_addr), .i_req(ds_req),
        .o_pm_data(pm_data), .o_ds_rdata(ds_rdata));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic results;
        $display("counts: %0d compared, %0d mismatched", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end

    task automatic check(input string what, input logic [47:0] seen,
                         input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] rnd8();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    // Keeps random code clear of halts, calls and returns
    function automatic logic allowed(input logic [7:0] b);
        case (b[3:0])
            4'h1: return 1'b0;
            4'h5: return !b[7];
            4'h7: return b[7:5] < 3'h6;
            4'hf: return b[7:5] < 3'h4 || (b[7:5] < 3'h7 && !b[4]);
            4'hd: return b[7:4] == 4'h0 || (b[7:4] > 4'h4 && b[7:4] < 4'h8);
            default: return 1'b1;
        endcase
    endfunction

    function automatic logic [7:0] rd(input logic [7:0] ad);
        if (ad == 8'hff) return m_a;
        if (ad[7:2] == 6'h20) return m_r[ad[1:0]];
        return m_ds[ad];
    endfunction

    task automatic wr(input logic [7:0] ad, input logic [7:0] v);
        if (ad == 8'hff) m_a = v;
        else if (ad[7:2] == 6'h20) m_r[ad[1:0]] = v;
        else m_ds[ad] = v;
    endtask

    task automatic alu(input logic [2:0] fn, input logic [7:0] ad,
                       input logic [7:0] m);
        logic [8:0] s;
        case (fn)
            3'h0: s = m_a + m;
            3'h1: s = {1'b0, m_a & m};
            3'h2, 3'h3: s = {1'b0, m_a} - {1'b0, m};
            default: s = {1'b0, m + (fn[0] ? 8'hff : 8'h01)};
        endcase
        m_z = (s[7:0] == 8'h00);
        if (fn < 3'h4) m_c = s[8];
        if (fn < 3'h4 && fn != 3'h2) m_a = s[7:0];
        if (fn > 3'h3) wr(ad, s[7:0]);
    endtask

    task automatic step(output int c);
        logic [7:0] op, b1, b2, v;
        logic [11:0] nx;
        logic [2:0] fn;
        op = mem.pm[m_pc];
        b1 = mem.pm[m_pc + 12'h1];
        b2 = mem.pm[m_pc + 12'h2];
        fn = op[7:5];
        c = 2;
        nx = m_pc + 12'h1;
        case (op[3:0])
            4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc, 4'he: begin
                if (op[2] ? (op[1] ? m_c : m_z) : (op[1] ? !m_c : !m_z)) begin
                    nx = m_pc + 12'h1 + {{7{op[7]}}, op[7:3]};
                end
            end
            4'h3: begin
                v = rd(b1);
                m_c = v[fn];
                c = 5;
                nx = m_pc + 12'h3;
                if (v[fn] == op[4]) nx = m_pc + 12'h2 + {{4{b2[7]}}, b2};
            end
            4'hb: begin
                v = rd(b1);
                v[fn] = op[4];
                wr(b1, v);
                c = 4;
                nx = m_pc + 12'h2;
            end
            4'h5: begin
                v = m_r[op[6:5]] + (op[4] ? 8'hff : 8'h01);
                m_r[op[6:5]] = v;
                m_z = (v == 8'h00);
                c = 4;
            end
            4'h7: begin
                v = op[4] ? m_r[1] : m_r[0];
                alu(fn, v, rd(v));
                c = 4;
            end
            4'hf: begin
                c = 4;
                nx = m_pc + 12'h2;
                if (fn == 3'h6) begin
                    wr(b1, 8'h00);
                    nx = m_pc + 12'h3;
                end else alu(fn, b1, op[4] ? b1 : rd(b1));
            end
            4'h1, 4'h9: begin
                if (!op[3]) stk.push_back(int'(m_pc + 12'h2));
                nx = {op[7:4], b1};
                c = 4;
            end
            4'hd: case (op[7:4])
                4'h1, 4'h2: begin
                    if (stk.size() > 0) nx = 12'(stk.pop_back());
                    if (op[5]) {m_z, m_c} = {m_sz, m_sc};
                end
                4'h3: if (wdg_sel) m_wt = 1'b1; else m_st = 1'b1;
                4'h4: m_wt = 1'b1;
                4'h5, 4'h6, 4'h7: begin
                    v = {m_a[6:0], op[4] ? 1'b0 : m_c};
                    if (op[7:4] == 4'h5) v = ~m_a;
                    m_c = m_a[7];
                    m_a = v;
                    m_z = (v == 8'h00);
                    c = 4;
                    if (op[7:4] == 4'h7) nx = m_pc + 12'h2;
                end
                default: ;
            endcase
            default: ;
        endcase
        m_pc = nx;
    endtask

    task automatic run(input int n, input int save_at);
        int c;
        for (int i = 0; i < n; i++) begin
            step(c);
            @(posedge sys_clk);
            @(negedge sys_clk) flag_save = 1'b0;
            repeat (4 * c - 1) @(posedge sys_clk);
            @(negedge sys_clk);
            check("pc", pm_addr, m_pc);
            check("acc", acc, m_a);
            check("flags", {zf, cf}, {m_z, m_c});
            if (i == save_at) begin
                flag_save = 1'b1;
                {m_sz, m_sc} = {m_z, m_c};
            end
        end
    endtask

    task automatic fill(input logic rnd);
        logic [7:0] b;
        for (int a = 0; a < 4096; a++) begin
            b = 8'h0d;
            if (rnd) begin
                do b = rnd8(); while (!allowed(b));
            end
            mem.pm[a] = b;
        end
        for (int a = 0; a < 256; a++) begin
            b = rnd8();
            mem.ds[a] = b;
            m_ds[a] = b;
        end
    endtask

    task automatic reset_core(input logic wdg);
        @(negedge sys_clk);
        {rst_n, wdg_sel, wake, flag_save} = {1'b0, wdg, 2'b00};
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        check("reset", {acc, zf, cf, wt, st, pm_addr, ds_req}, 48'h0);
        rst_n = 1'b1;
        {m_pc, m_a, m_z, m_c, m_sz, m_sc, m_wt, m_st} = '0;
        m_r = '{default: 8'h00};
        stk.delete();
    endtask

    task automatic put(input logic [11:0] a, input logic [7:0] b0, b1, b2,
                       input int n);
        mem.pm[a] = b0;
        if (n > 1) mem.pm[a + 12'h1] = b1;
        if (n > 2) mem.pm[a + 12'h2] = b2;
    endtask

    initial begin
        {rst_n, wdg_sel, wake, flag_save} = 4'h0;
        fill(1'b1);
        reset_core(1'b0);
        run(400, -1);
        // The final write reaches memory one clock after the last cycle
        repeat (2) @(negedge sys_clk);
        for (int a = 0; a < 256; a++) begin
            check("ds", mem.ds[a], m_ds[a]);
        end
        $display("test random_code done");
        fill(1'b0);
        put(12'h000, 8'h1f, 8'h00, 8'h00, 2);
        put(12'h002, 8'h11, 8'h00, 8'h00, 2);
        put(12'h100, 8'h1f, 8'hff, 8'h00, 2);
        put(12'h102, 8'h1f, 8'h01, 8'h00, 2);
        put(12'h104, 8'h2d, 8'h00, 8'h00, 1);
        // Short jump span ends: +16 taken, -15 both ways
        put(12'h004, 8'h7c, 8'h00, 8'h00, 1);
        put(12'h014, 8'h80, 8'h00, 8'h00, 1);
        put(12'h015, 8'h84, 8'h00, 8'h00, 1);
        // Bit test span ends: +129 then -126
        put(12'h006, 8'h13, 8'h40, 8'h7f, 3);
        put(12'h087, 8'he3, 8'h40, 8'h80, 3);
        put(12'h009, 8'h1d, 8'h00, 8'h00, 1);
        put(12'h00a, 8'h39, 8'h21, 8'h00, 2);
        mem.ds[8'h40] = 8'h01;
        m_ds[8'h40] = 8'h01;
        reset_core(1'b0);
        run(12, 0);
        $display("test branch_call done");
        for (int k = 0; k < 3; k++) begin
            mem.pm[0] = (k == 2) ? 8'h4d : 8'h3d;
            reset_core(k == 1);
            run(1, -1);
            @(posedge sys_clk);
            @(negedge sys_clk);
            check("halt", {wt, st}, {m_wt, m_st});
            wake = 1'b1;
            repeat (2) @(negedge sys_clk);
            wake = 1'b0;
            check("wake", {wt, st}, 2'b00);
        end
        $display("test halt done");
        results();
    end
endmodule
